/* File: src/flash_space.sv */
/*
 * address-space logic of a serial nor flash: address forming, main array
 * decode, id and parameter spaces, security regions with protection, and
 * nonvolatile/volatile configuration register pairs, behind axi4-lite.
 * assumes one clock, synchronous active-low resets, a well-behaved master.
 */
// Notes on behaviour
// - extended-address bit set: legacy commands take a four-byte address.
// - dedicated four-byte commands always take a 32-bit address.
// - after any reset, extended mode comes from a nonvolatile bit.
// - three-byte mode reaches lowest 16 MB; four-byte covers whole array.
// - auxiliary spaces take full-width addresses, sparsely populated.
// - main array decodes to 512 blocks, 1024 half blocks, 8192 sectors.
// - identification command reads a fixed, unwritable id space.
// - id space holds an eight-byte unique number.
// - parameter command reads read-only table that includes the id.
// - security space is 1024 bytes in four 256-byte regions.
// - regions start erased; unprotected ones program and erase per region.
// - one-time lock bits, one per region, block program and erase.
// - volatile region lock blocks program and erase of regions 2, 3.
// - password bit blocks program and erase of regions 2, 3.
// - read-protect bit hides region 3 reads until password given.
// - blocked program or erase sets program or erase error flag.
// - every reset copies nonvolatile images into volatile ones.
// - nonvolatile write rewrites image, then refreshes volatile copy.
// - reading either register form returns the volatile image.
// - one-time programming updates nonvolatile and matching volatile bits.
// - volatile write changes only volatile bits.
`timescale 1ns/1ns
`default_nettype none

module flash_space #(
   parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // arbitrary
   parameter logic [31:0] PASSWORD  = 32'h5a5aa5a5
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        hard_reset_n,
   // axi4-lite write address
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   // axi4-lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read address
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   // axi4-lite read data
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready
);

   flash_space_pkg::state_s q;
   flash_space_pkg::state_s n;
   logic [7:0]              sec_mem [flash_space_pkg::SEC_BYTES];
   logic                    mem_we;
   logic [9:0]              mem_addr;
   logic [7:0]              mem_wd;
   logic [31:0]             ia;
   logic [1:0]              region;
   logic [7:0]              sec_rd;
   logic                    pe_blocked;
   logic                    rd_blocked;
   logic                    four_byte;
   logic                    sel2;

   // internal address from the host address and the width in force
   function automatic logic [31:0] form_addr(input logic [31:0] a, input logic four);
      if (four)
         return a;
      return {8'h00, a[23:0]};
   endfunction

   function automatic flash_space_pkg::decode_s decode_main(input logic [31:0] a);
      flash_space_pkg::decode_s d;
      d.block  = a[flash_space_pkg::MAIN_AW-1:flash_space_pkg::BLOCK_LSB];
      d.half   = a[flash_space_pkg::MAIN_AW-1:flash_space_pkg::HALF_LSB];
      d.sector = a[flash_space_pkg::MAIN_AW-1:flash_space_pkg::SECTOR_LSB];
      return d;
   endfunction

   // id space: eight populated bytes, rest of the range reads unpopulated
   function automatic logic [7:0] id_byte(input logic [31:0] a);
      if (a[31:flash_space_pkg::ID_AW] != '0)
         return flash_space_pkg::UNPOPULATED;
      return UNIQUE_ID[{a[2:0], 3'b000} +: 8];
   endfunction

   // parameter table: header, then the id bytes as one parameter
   function automatic logic [7:0] param_byte(input logic [31:0] a);
      if (a[31:flash_space_pkg::PARAM_AW] != '0)
         return flash_space_pkg::UNPOPULATED;
      case (a[3:0])
         4'h0:    return 8'h53;
         4'h1:    return 8'h46;
         4'h2:    return 8'h44;
         4'h3:    return 8'h50;
         4'h4:    return 8'h00;
         4'h5:    return 8'h01;
         4'h6:    return 8'h00;
         4'h7:    return 8'hff;
         default: return id_byte({29'h0, a[2:0]});
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // reset copy of nonvolatile images into the volatile side
   function automatic flash_space_pkg::state_s reset_copy(input flash_space_pkg::state_s s);
      flash_space_pkg::state_s r;
      r = s;
      r.cfg1_v      = s.cfg1_nv;
      r.cfg2_v      = s.cfg2_nv;
      r.region_lock = flash_space_pkg::REGION_LOCK_RST;
      r.pass_ok     = 1'b0;
      return r;
   endfunction

   assign four_byte = q.wdata[flash_space_pkg::CMD_FOUR_BYTE_BIT]
                      | q.cfg2_v[flash_space_pkg::CFG2_EXT_BIT];
   assign sel2      = q.wdata[flash_space_pkg::CMD_REG_SEL_BIT];
   assign ia        = form_addr(q.addr, four_byte);
   assign region    = ia[9:8];
   assign sec_rd    = sec_mem[ia[flash_space_pkg::SEC_AW-1:0]];

   // program/erase and read protection of the addressed region
   always_comb begin
      pe_blocked = q.cfg1_v[flash_space_pkg::LOCK_LSB + 32'(region)];
      if (region[1]) begin
         if (q.region_lock)
            pe_blocked = 1'b1;
         if (q.region_protect_register[flash_space_pkg::IRP_PASS_BIT] && !q.pass_ok)
            pe_blocked = 1'b1;
      end
      rd_blocked = (region == 2'd3) && q.region_protect_register[flash_space_pkg::IRP_READ_BIT] && !q.pass_ok;
   end

   always_comb begin
      n        = q;
      mem_we   = 1'b0;
      mem_addr = q.sweep_ptr;
      mem_wd   = flash_space_pkg::ERASED;

      // erase sweep writes one byte per cycle
      if (q.mode == flash_space_pkg::ST_SWEEP) begin
         mem_we = 1'b1;
         if (q.sweep_ptr == q.sweep_end)
            n.mode = flash_space_pkg::ST_IDLE;
         else
            n.sweep_ptr = 10'(q.sweep_ptr + 10'h001);
      end

      // read channel
      if (q.rvalid && rready)
         n.rvalid = 1'b0;
      if (arvalid && q.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = flash_space_pkg::RESP_OKAY;
         n.rdata  = '0;
         case (araddr)
            flash_space_pkg::OFS_CMD,
            flash_space_pkg::OFS_PASSWORD,
            flash_space_pkg::OFS_SWRESET: n.rdata = '0;
            flash_space_pkg::OFS_ADDR:     n.rdata = q.addr;
            flash_space_pkg::OFS_DATA:     n.rdata = {24'h0, q.data};
            flash_space_pkg::OFS_RESULT:   n.rdata = {24'h0, q.result};
            flash_space_pkg::OFS_STATUS: begin
               n.rdata[flash_space_pkg::SR_BUSY_BIT]      = (q.mode == flash_space_pkg::ST_SWEEP);
               n.rdata[flash_space_pkg::SR_EXT_BIT]       = q.cfg2_v[flash_space_pkg::CFG2_EXT_BIT];
               n.rdata[flash_space_pkg::SR_RANGE_BIT]     = q.range_err;
               n.rdata[flash_space_pkg::SR_ERASE_ERR_BIT] = q.erase_err;
               n.rdata[flash_space_pkg::SR_PROG_ERR_BIT]  = q.prog_err;
            end
            flash_space_pkg::OFS_INT_ADDR: n.rdata = q.int_addr;
            flash_space_pkg::OFS_DECODE:   n.rdata = q.decode;
            flash_space_pkg::OFS_PROT: begin
               n.rdata[flash_space_pkg::PROT_LOCK_BIT]             = q.region_lock;
               n.rdata[flash_space_pkg::PROT_PASS_BIT]             = q.pass_ok;
               n.rdata[flash_space_pkg::PROT_IRP_LSB +: 8]         = q.region_protect_register;
            end
            default: n.rresp = flash_space_pkg::RESP_DECERR;
         endcase
      end

      // write channels, taken in either order
      if (awvalid && q.awready) begin
         n.aw_got = 1'b1;
         n.waddr  = awaddr;
      end
      if (wvalid && q.wready) begin
         n.w_got = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (q.bvalid && bready)
         n.bvalid = 1'b0;

      if (q.aw_got && q.w_got && !q.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = flash_space_pkg::RESP_OKAY;
         case (q.waddr)
            flash_space_pkg::OFS_ADDR: n.addr = merge(q.addr, q.wdata, q.wstrb);
            flash_space_pkg::OFS_DATA: begin
               if (q.wstrb[0])
                  n.data = q.wdata[7:0];
            end
            flash_space_pkg::OFS_STATUS: begin
               // write one to clear; hardware never sets in the same write
               if (q.wstrb[0]) begin
                  n.range_err = q.range_err & ~q.wdata[flash_space_pkg::SR_RANGE_BIT];
                  n.erase_err = q.erase_err & ~q.wdata[flash_space_pkg::SR_ERASE_ERR_BIT];
                  n.prog_err  = q.prog_err & ~q.wdata[flash_space_pkg::SR_PROG_ERR_BIT];
               end
            end
            flash_space_pkg::OFS_PROT: begin
               if (q.wstrb[0])
                  n.region_lock = q.wdata[flash_space_pkg::PROT_LOCK_BIT];
               if (q.wstrb[1])
                  n.region_protect_register = q.wdata[flash_space_pkg::PROT_IRP_LSB +: 8];
            end
            flash_space_pkg::OFS_PASSWORD: n.pass_ok = (q.wdata == PASSWORD);
            flash_space_pkg::OFS_SWRESET:  n = reset_copy(n);
            flash_space_pkg::OFS_RESULT,
            flash_space_pkg::OFS_INT_ADDR,
            flash_space_pkg::OFS_DECODE: ;
            flash_space_pkg::OFS_CMD: begin
               if (q.mode != flash_space_pkg::ST_IDLE || !q.wstrb[0] || !q.wstrb[1]) begin
                  n.bresp = flash_space_pkg::RESP_SLVERR;
               end else begin
                  n.int_addr = ia;
                  case (q.wdata[7:0])
                     flash_space_pkg::OP_READ_MAIN,
                     flash_space_pkg::OP_PROGRAM_MAIN,
                     flash_space_pkg::OP_ERASE_SECTOR,
                     flash_space_pkg::OP_ERASE_HALF,
                     flash_space_pkg::OP_ERASE_BLOCK: begin
                        n.decode = decode_main(ia);
                        if (ia[31:flash_space_pkg::MAIN_AW] != '0)
                           n.range_err = 1'b1;
                     end
                     flash_space_pkg::read_identification_cmd:  n.result = id_byte(ia);
                     flash_space_pkg::read_parameter_table_cmd: n.result = param_byte(ia);
                     flash_space_pkg::OP_SEC_READ: begin
                        if (ia[31:flash_space_pkg::SEC_AW] != '0) begin
                           n.range_err = 1'b1;
                           n.result    = flash_space_pkg::UNPOPULATED;
                        end else if (rd_blocked) begin
                           n.result = flash_space_pkg::HIDDEN;
                        end else begin
                           n.result = sec_rd;
                        end
                     end
                     flash_space_pkg::OP_SEC_PROGRAM: begin
                        if (ia[31:flash_space_pkg::SEC_AW] != '0) begin
                           n.range_err = 1'b1;
                        end else if (pe_blocked) begin
                           n.prog_err = 1'b1;
                        end else begin
                           mem_we   = 1'b1;
                           mem_addr = ia[flash_space_pkg::SEC_AW-1:0];
                           mem_wd   = sec_rd & q.data;
                        end
                     end
                     flash_space_pkg::OP_SEC_ERASE: begin
                        if (ia[31:flash_space_pkg::SEC_AW] != '0) begin
                           n.range_err = 1'b1;
                        end else if (pe_blocked) begin
                           n.erase_err = 1'b1;
                        end else begin
                           n.mode      = flash_space_pkg::ST_SWEEP;
                           n.sweep_ptr = {region, 8'h00};
                           n.sweep_end = {region, 8'hff};
                        end
                     end
                     flash_space_pkg::OP_REG_READ: n.result = sel2 ? q.cfg2_v : q.cfg1_v;
                     flash_space_pkg::OP_REG_WRITE_NV: begin
                        if (sel2) begin
                           n.cfg2_nv = q.data;
                           n.cfg2_v  = q.data;
                        end else begin
                           n.cfg1_nv = (q.data & ~flash_space_pkg::OTP_MASK1)
                                       | (q.cfg1_nv & flash_space_pkg::OTP_MASK1);
                           n.cfg1_v  = n.cfg1_nv;
                        end
                     end
                     flash_space_pkg::OP_OTP_PROGRAM: begin
                        n.cfg1_nv = q.cfg1_nv | (q.data & flash_space_pkg::OTP_MASK1);
                        n.cfg1_v  = q.cfg1_v | (q.data & flash_space_pkg::OTP_MASK1);
                     end
                     flash_space_pkg::OP_REG_WRITE_V: begin
                        if (sel2)
                           n.cfg2_v = q.data;
                        else
                           n.cfg1_v = (q.cfg1_v & ~flash_space_pkg::CFG1_V_WR_MASK)
                                      | (q.data & flash_space_pkg::CFG1_V_WR_MASK);
                     end
                     default: n.bresp = flash_space_pkg::RESP_SLVERR;
                  endcase
               end
            end
            default: n.bresp = flash_space_pkg::RESP_DECERR;
         endcase
      end

      if (!hard_reset_n)
         n = reset_copy(n);

      n.awready = !n.aw_got && !n.bvalid;
      n.wready  = !n.w_got && !n.bvalid;
      n.arready = !n.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q           <= '0;
         q.awready   <= 1'b1;
         q.wready    <= 1'b1;
         q.arready   <= 1'b1;
         q.cfg1_nv   <= flash_space_pkg::CFG1_NV_RST;
         q.cfg2_nv   <= flash_space_pkg::CFG2_NV_RST;
         q.cfg1_v    <= flash_space_pkg::CFG1_NV_RST;
         q.cfg2_v    <= flash_space_pkg::CFG2_NV_RST;
         q.region_protect_register       <= flash_space_pkg::IRP_RST;
         q.region_lock <= flash_space_pkg::REGION_LOCK_RST;
         q.mode      <= flash_space_pkg::ST_SWEEP;
         q.sweep_end <= 10'h3ff;
      end else begin
         q <= n;
      end
   end

   // security space storage, no reset; filled with erased bytes by the sweep
   always_ff @(posedge aclk) begin
      if (mem_we)
         sec_mem[mem_addr] <= mem_wd;
   end

   assign awready = q.awready;
   assign wready  = q.wready;
   assign bvalid  = q.bvalid;
   assign bresp   = q.bresp;
   assign arready = q.arready;
   assign rvalid  = q.rvalid;
   assign rresp   = q.rresp;
   assign rdata   = q.rdata;

endmodule // flash_space

`default_nettype wire

/* File: src/flash_space_pkg.sv */
/*
 * constants, command codes and state types for the flash address-space block.
 * assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
 */
package flash_space_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CMD      = 8'h00;
   localparam logic [7:0] OFS_ADDR     = 8'h04;
   localparam logic [7:0] OFS_DATA     = 8'h08;
   localparam logic [7:0] OFS_RESULT   = 8'h0c;
   localparam logic [7:0] OFS_STATUS   = 8'h10;
   localparam logic [7:0] OFS_INT_ADDR = 8'h14;
   localparam logic [7:0] OFS_DECODE   = 8'h18;
   localparam logic [7:0] OFS_PROT     = 8'h1c;
   localparam logic [7:0] OFS_PASSWORD = 8'h20;
   localparam logic [7:0] OFS_SWRESET  = 8'h24;

   // command opcodes
   localparam logic [7:0] OP_READ_MAIN             = 8'h01;
   localparam logic [7:0] OP_PROGRAM_MAIN          = 8'h02;
   localparam logic [7:0] OP_ERASE_SECTOR          = 8'h03;
   localparam logic [7:0] OP_ERASE_HALF            = 8'h04;
   localparam logic [7:0] OP_ERASE_BLOCK           = 8'h05;
   localparam logic [7:0] OP_SEC_READ              = 8'h06;
   localparam logic [7:0] OP_SEC_PROGRAM           = 8'h07;
   localparam logic [7:0] OP_SEC_ERASE             = 8'h08;
   localparam logic [7:0] OP_REG_READ              = 8'h09;
   localparam logic [7:0] OP_REG_WRITE_NV          = 8'h0a;
   localparam logic [7:0] OP_REG_WRITE_V           = 8'h0b;
   localparam logic [7:0] OP_OTP_PROGRAM           = 8'h0c;
   localparam logic [7:0] read_identification_cmd  = 8'h9f;
   localparam logic [7:0] read_parameter_table_cmd = 8'h5a;

   // command register fields
   localparam int CMD_FOUR_BYTE_BIT = 8;
   localparam int CMD_REG_SEL_BIT   = 9;

   // status register bits
   localparam int SR_BUSY_BIT      = 0;
   localparam int SR_EXT_BIT       = 1;
   localparam int SR_RANGE_BIT     = 2;
   localparam int SR_ERASE_ERR_BIT = 5;
   localparam int SR_PROG_ERR_BIT  = 6;

   // protection register fields
   localparam int PROT_LOCK_BIT = 0;
   localparam int PROT_PASS_BIT = 1;
   localparam int PROT_IRP_LSB  = 8;
   localparam int IRP_PASS_BIT  = 2;
   localparam int IRP_READ_BIT  = 6;

   // configuration registers
   localparam int         LOCK_LSB       = 2;
   localparam int         CFG2_EXT_BIT   = 0;
   localparam logic [7:0] OTP_MASK1      = 8'h3c;
   localparam logic [7:0] CFG1_V_WR_MASK = 8'hc3;
   localparam logic [7:0] CFG1_NV_RST    = 8'h00;
   localparam logic [7:0] CFG2_NV_RST    = 8'h00;
   localparam logic [7:0] IRP_RST        = 8'h00;
   localparam logic       REGION_LOCK_RST = 1'b0;

   // address spaces
   localparam int         SEC_AW     = 10;
   localparam int         SEC_BYTES  = 1024;
   localparam int         MAIN_AW    = 25;
   localparam int         BLOCK_LSB  = 16;
   localparam int         HALF_LSB   = 15;
   localparam int         SECTOR_LSB = 12;
   localparam int         ID_AW      = 3;
   localparam int         PARAM_AW   = 4;
   localparam logic [7:0] ERASED     = 8'hff;
   localparam logic [7:0] HIDDEN     = 8'h00;
   localparam logic [7:0] UNPOPULATED = 8'hff;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef enum logic {ST_IDLE, ST_SWEEP} mode_e;

   typedef struct packed {
      logic [8:0]  block;
      logic [9:0]  half;
      logic [12:0] sector;
   } decode_s;

   typedef struct packed {
      logic         awready;
      logic         wready;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         aw_got;
      logic         w_got;
      logic [7:0]   waddr;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         arready;
      logic         rvalid;
      logic [1:0]   rresp;
      logic [31:0]  rdata;
      logic [7:0]   cfg1_nv;
      logic [7:0]   cfg2_nv;
      logic [7:0]   cfg1_v;
      logic [7:0]   cfg2_v;
      logic         region_lock;
      logic [7:0]   region_protect_register;
      logic         pass_ok;
      logic [31:0]  addr;
      logic [7:0]   data;
      logic [31:0]  int_addr;
      decode_s      decode;
      logic [7:0]   result;
      logic         prog_err;
      logic         erase_err;
      logic         range_err;
      mode_e        mode;
      logic [9:0]   sweep_ptr;
      logic [9:0]   sweep_end;
   } state_s;

endpackage

/* File: tb/flash_host.sv */
/* axi4-lite host model for flash_space, one transfer at a time.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/1ns
`default_nettype none
module flash_host (
   // clock
   input  wire logic        aclk,
   // write side
   output logic [7:0]       awaddr = 8'h00,
   output logic             awvalid = 1'b0,
   input  wire logic        awready,
   output logic [31:0]      wdata = 32'h0,
   output logic [3:0]       wstrb = 4'hf,
   output logic             wvalid = 1'b0,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready = 1'b0,
   // read side
   output logic [7:0]       araddr = 8'h00,
   output logic             arvalid = 1'b0,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready = 1'b0
);
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // flash_host
`default_nettype wire

/* File: tb/flash_space_checker.sv */
/* bus timing checker for flash_space.
   assumes one clock and the synchronous active-low aresetn. */
`timescale 1ns/1ns
`default_nettype none
module flash_space_checker (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // write side
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   // read side
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wr_lat; awvalid && awready && wvalid && wready |-> !bvalid ##2 bvalid; endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write answer not two cycles on");
   property p_wr_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write answer dropped");
   property p_wr_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
   a_wr_done: assert property (p_wr_done) else $error("write not reopened");
   property p_aw_block; bvalid |-> !awready && !wready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("write accepted twice");
   property p_rd_lat; arvalid && arready |=> rvalid && !arready; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_rd_hold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_rd_done; rvalid && rready |=> !rvalid && arready; endproperty
   a_rd_done: assert property (p_rd_done) else $error("read not reopened");
   property p_ar_block; rvalid |-> !arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read accepted twice");
endmodule // flash_space_checker
bind flash_space flash_space_checker u_chk (.*);
`default_nettype wire

/* File: tb/tb_flash_space.sv */
/* self-checking bench for flash_space.
   assumes flash_host as bus master and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module tb_flash_space;
   localparam logic [63:0] UID = 64'h1122334455667788; // arbitrary
   localparam logic [31:0] PW  = 32'hc0de1234;
   logic             aclk = 1'b0;
   logic             aresetn = 1'b0;
   logic             hard_reset_n = 1'b1;
   wire logic [7:0]  awaddr, araddr;
   wire logic [31:0] wdata, rdata;
   wire logic [3:0]  wstrb;
   wire logic [1:0]  bresp, rresp;
   wire logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   int               bad_count = 0;
   int               checked = 0;
   int               cyc = 0;
   flash_space #(.UNIQUE_ID(UID), .PASSWORD(PW)) u_dut (.*);
   flash_host u_host (.*);
   always #2 aclk = ~aclk;
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      u_host.rd(a, d, r);
      cmp(d & m, e);
      cmp({30'h0, r}, {30'h0, (a == 8'h3c) ? flash_space_pkg::RESP_DECERR : flash_space_pkg::RESP_OKAY});
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic [1:0] r;
      u_host.wr(a, d, r);
      cmp({30'h0, r}, {30'h0, e});
   endtask
   task automatic cmd(input logic [9:0] op, input logic [31:0] a, input logic [7:0] d);
      put(8'h04, a, 2'b00);
      put(8'h08, {24'h0, d}, 2'b00);
      put(8'h00, {22'h0, op}, 2'b00);
   endtask
   task automatic t_boot;
      logic [31:0] d;
      logic [1:0]  r;
      do u_host.rd(8'h10, d, r); while (d[0] !== 1'b0);
      chk(8'h10, 32'h2, 32'h0);
      chk(8'h3c, 32'hffffffff, 32'h0);
      put(8'h3c, 32'h0, flash_space_pkg::RESP_DECERR);
      put(8'h00, 32'h3ee, flash_space_pkg::RESP_SLVERR);
   endtask
   task automatic t_addr;
      cmd(10'h001, 32'h12345678, 8'h0);
      chk(8'h14, 32'hffffffff, 32'h00345678);
      cmd(10'h101, 32'h01345678, 8'h0);
      chk(8'h14, 32'hffffffff, 32'h01345678);
      cmd(10'h103, 32'h00018000, 8'h0);
      chk(8'h18, 32'hffffffff, 32'h00806018);
      cmd(10'h105, 32'h02000000, 8'h0);
      chk(8'h10, 32'h4, 32'h4);
      put(8'h10, 32'h64, 2'b00);
   endtask
   task automatic t_space;
      cmd(10'h09f, 32'h0, 8'h0);
      chk(8'h0c, 32'hff, {24'h0, UID[7:0]});
      cmd(10'h09f, 32'h8, 8'h0);
      chk(8'h0c, 32'hff, 32'hff);
      cmd(10'h05a, 32'h3, 8'h0);
      chk(8'h0c, 32'hff, 32'h50);
      cmd(10'h05a, 32'h8, 8'h0);
      chk(8'h0c, 32'hff, {24'h0, UID[7:0]});
   endtask
   task automatic t_sec;
      cmd(10'h006, 32'h3ff, 8'h0);
      chk(8'h0c, 32'hff, 32'hff);
      cmd(10'h007, 32'h3ff, 8'h5a);
      cmd(10'h006, 32'h3ff, 8'h0);
      chk(8'h0c, 32'hff, 32'h5a);
      put(8'h1c, 32'h1, 2'b00);
      cmd(10'h007, 32'h200, 8'h00);
      chk(8'h10, 32'h40, 32'h40);
      put(8'h1c, 32'h4400, 2'b00);
      put(8'h10, 32'h64, 2'b00);
      cmd(10'h008, 32'h300, 8'h0);
      chk(8'h10, 32'h20, 32'h20);
      cmd(10'h006, 32'h3ff, 8'h0);
      chk(8'h0c, 32'hff, 32'h00);
      put(8'h20, PW, 2'b00);
      cmd(10'h006, 32'h3ff, 8'h0);
      chk(8'h0c, 32'hff, 32'h5a);
      cmd(10'h008, 32'h300, 8'h0);
      repeat (260) @(posedge aclk);
      cmd(10'h006, 32'h3ff, 8'h0);
      chk(8'h0c, 32'hff, 32'hff);
      cmd(10'h00c, 32'h0, 8'h04);
      cmd(10'h009, 32'h0, 8'h0);
      chk(8'h0c, 32'h04, 32'h04);
      put(8'h10, 32'h64, 2'b00);
      cmd(10'h007, 32'h010, 8'h00);
      chk(8'h10, 32'h40, 32'h40);
   endtask
   task automatic t_shadow;
      cmd(10'h20a, 32'h0, 8'h01);
      chk(8'h10, 32'h2, 32'h2);
      cmd(10'h209, 32'h0, 8'h0);
      chk(8'h0c, 32'hff, 32'h01);
      cmd(10'h001, 32'h12345678, 8'h0);
      chk(8'h14, 32'hffffffff, 32'h12345678);
      cmd(10'h20b, 32'h0, 8'h00);
      chk(8'h10, 32'h2, 32'h0);
      put(8'h24, 32'h0, 2'b00);
      chk(8'h10, 32'h2, 32'h2);
      cmd(10'h20b, 32'h0, 8'h00);
      @(posedge aclk);
      hard_reset_n <= 1'b0;
      @(posedge aclk);
      hard_reset_n <= 1'b1;
      chk(8'h10, 32'h2, 32'h2);
   endtask
   task automatic close_out;
      if (bad_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_boot();
      t_addr();
      t_space();
      t_sec();
      t_shadow();
      close_out();
   end
endmodule // tb_flash_space
`default_nettype wire
